// ---- scs_sequencer.sv ----
`timescale 1ns/1ns
`default_nettype none
module scs_sequencer
   import scs_pkg::*;
#(
   parameter int unsigned MS_CYCLES = SCS_MS_CYCLES,
   parameter int unsigned SCK_HALF = SCS_SCK_HALF_CYCLES,
   parameter int unsigned STEP_DEPTH = SCS_STEP_DEPTH,
   parameter int unsigned FIFO_DEPTH = SCS_FIFO_DEPTH
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic load_valid_i,
   output logic load_ready_o,
   input wire logic load_list_i,
   input wire logic [$clog2(STEP_DEPTH)-1:0] load_index_i,
   input wire scs_step_type load_step_i,
   input wire logic connect_req_i,
   input wire logic program_done_i,
   output logic connected_o,
   output logic connect_done_o,
   output logic finish_done_o,
   output logic busy_o,
   output logic rd_valid_o,
   input wire logic rd_ready_i,
   output logic [7:0] rd_data_o,
   output logic spi_sck_o,
   output logic spi_mosi_o,
   output logic spi_cs_n_o,
   input wire logic spi_miso_i
);
   localparam int unsigned PC_W = $clog2(STEP_DEPTH);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FETCH,
      ST_DECODE,
      ST_DELAY,
      ST_XFER,
      ST_WAIT,
      ST_NEXT,
      ST_LIST_END
   } scs_state_type;

   scs_step_type step_mem [2*STEP_DEPTH];
   logic [7:0] buf_mem [SCS_BUF_BYTES];

   scs_state_type state_reg;
   scs_state_type state_next;
   logic list_reg;
   logic list_next;
   logic [PC_W-1:0] pc_reg;
   logic [PC_W-1:0] pc_next;
   scs_step_type step_reg;
   scs_step_type step_next;
   logic cs_n_reg;
   logic cs_n_next;
   logic [15:0] ms_reg;
   logic [15:0] ms_next;
   logic [31:0] cyc_reg;
   logic [31:0] cyc_next;
   logic [4:0] idx_reg;
   logic [4:0] idx_next;
   logic [4:0] cnt_reg;
   logic [4:0] cnt_next;
   logic connected_reg;
   logic connected_next;
   logic conn_done_reg;
   logic conn_done_next;
   logic fin_done_reg;
   logic fin_done_next;

   scs_spi_out_type spi_out;
   logic spi_done;
   logic [7:0] spi_rx;
   logic fifo_in_ready;

   // Step decode
   wire scs_action_type act = step_reg.action;
   wire is_write = act == SCS_ACT_WRITE;
   wire is_vread = act == SCS_ACT_VREAD;
   wire is_vwrite = act == SCS_ACT_VWRITE;
   wire is_logic = act == SCS_ACT_VAND || act == SCS_ACT_VOR ||
      act == SCS_ACT_VXOR;
   wire [15:0] count_raw = is_write ? step_reg.first_operand :
      {8'h00, step_reg.second_operand};
   wire count_big = count_raw > 16'(SCS_MAX_COUNT);
   wire [4:0] count_cap = count_big ? SCS_MAX_COUNT : count_raw[4:0];
   wire last_byte = idx_reg == cnt_reg - 5'h01;
   wire last_pc = pc_reg == PC_W'(STEP_DEPTH - 1);
   wire ms_tick = cyc_reg == 32'(MS_CYCLES - 1);

   // Offset plus index wraps inside the buffer
   wire [3:0] buf_offset = step_reg.first_operand[3:0];
   wire [3:0] byte_position = step_reg.first_operand[3:0];
   wire [3:0] stream_addr = buf_offset + idx_reg[3:0];
   wire [3:0] buf_addr = (is_vread || is_vwrite) ? stream_addr :
      byte_position;
   wire [7:0] buf_rd = buf_mem[buf_addr];
   wire [7:0] list_byte = step_reg.byte_list[{idx_reg[3:0], 3'b000} +: 8];

   // Filler byte still clocks eight bits
   wire [7:0] tx_byte = is_write ? list_byte :
      is_vwrite ? buf_rd :
      SCS_FILL_BYTE;

   // A read byte only starts when the FIFO has room for it
   wire spi_start = state_reg == ST_XFER && (!is_vread || fifo_in_ready);
   wire rx_push = state_reg == ST_WAIT && spi_done && is_vread;

   wire [7:0] and_val = buf_rd & step_reg.second_operand;
   wire [7:0] or_val = buf_rd | step_reg.second_operand;
   wire [7:0] xor_val = buf_rd ^ step_reg.second_operand;
   wire [7:0] mod_val = act == SCS_ACT_VAND ? and_val :
      act == SCS_ACT_VOR ? or_val : xor_val;
   wire mod_we = state_reg == ST_DECODE && is_logic;
   wire buf_we = mod_we || rx_push;
   wire [7:0] buf_wd = rx_push ? spi_rx : mod_val;

   wire load_we = load_valid_i && load_ready_o;

   assign load_ready_o = state_reg == ST_IDLE;
   assign busy_o = state_reg != ST_IDLE;
   assign connected_o = connected_reg;
   assign connect_done_o = conn_done_reg;
   assign finish_done_o = fin_done_reg;
   assign spi_cs_n_o = cs_n_reg;
   assign spi_sck_o = spi_out.sck;
   assign spi_mosi_o = spi_out.mosi;
   assign spi_out.cs_n = cs_n_reg;

   always_comb
   begin
      state_next = state_reg;
      list_next = list_reg;
      pc_next = pc_reg;
      step_next = step_reg;
      cs_n_next = cs_n_reg;
      ms_next = ms_reg;
      cyc_next = cyc_reg;
      idx_next = idx_reg;
      cnt_next = cnt_reg;
      connected_next = connected_reg;
      conn_done_next = 1'b0;
      fin_done_next = 1'b0;
      case (state_reg)
         ST_IDLE:
         begin
            if (connect_req_i)
            begin
               list_next = SCS_LIST_CONNECT;
               pc_next = '0;
               connected_next = 1'b0;
               state_next = ST_FETCH;
            end
            else if (program_done_i && connected_reg)
            begin
               list_next = SCS_LIST_FINISH;
               pc_next = '0;
               state_next = ST_FETCH;
            end
         end
         ST_FETCH:
         begin
            step_next = step_mem[{list_reg, pc_reg}];
            state_next = ST_DECODE;
         end
         ST_DECODE:
         begin
            state_next = ST_NEXT;
            case (act)
               SCS_ACT_END:
                  state_next = ST_LIST_END;
               SCS_ACT_CS_LOW:
                  cs_n_next = 1'b0;
               SCS_ACT_CS_HIGH:
                  cs_n_next = 1'b1;
               SCS_ACT_DELAY:
               begin
                  ms_next = step_reg.first_operand;
                  cyc_next = '0;
                  state_next = ST_DELAY;
               end
               SCS_ACT_WRITE, SCS_ACT_VREAD, SCS_ACT_VWRITE:
               begin
                  idx_next = 5'h00;
                  cnt_next = count_cap;
                  state_next = count_cap == 5'h00 ? ST_NEXT : ST_XFER;
               end
               default:
                  state_next = ST_NEXT;
            endcase
         end
         ST_DELAY:
         begin
            if (ms_reg == 16'h0000)
               state_next = ST_NEXT;
            else if (ms_tick)
            begin
               cyc_next = '0;
               ms_next = ms_reg - 16'h0001;
            end
            else
               cyc_next = cyc_reg + 32'h0000_0001;
         end
         ST_XFER:
         begin
            if (spi_start)
               state_next = ST_WAIT;
         end
         ST_WAIT:
         begin
            if (spi_done)
            begin
               idx_next = idx_reg + 5'h01;
               state_next = last_byte ? ST_NEXT : ST_XFER;
            end
         end
         ST_NEXT:
         begin
            pc_next = pc_reg + 1'b1;
            state_next = last_pc ? ST_LIST_END : ST_FETCH;
         end
         ST_LIST_END:
         begin
            if (list_reg == SCS_LIST_CONNECT)
            begin
               connected_next = 1'b1;
               conn_done_next = 1'b1;
            end
            else
               fin_done_next = 1'b1;
            state_next = ST_IDLE;
         end
         default:
            state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= ST_IDLE;
         list_reg <= SCS_LIST_CONNECT;
         pc_reg <= '0;
         step_reg <= '0;
         cs_n_reg <= SCS_CS_N_RESET;
         ms_reg <= 16'h0000;
         cyc_reg <= 32'h0000_0000;
         idx_reg <= 5'h00;
         cnt_reg <= 5'h00;
         connected_reg <= 1'b0;
         conn_done_reg <= 1'b0;
         fin_done_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         list_reg <= list_next;
         pc_reg <= pc_next;
         step_reg <= step_next;
         cs_n_reg <= cs_n_next;
         ms_reg <= ms_next;
         cyc_reg <= cyc_next;
         idx_reg <= idx_next;
         cnt_reg <= cnt_next;
         connected_reg <= connected_next;
         conn_done_reg <= conn_done_next;
         fin_done_reg <= fin_done_next;
      end
   end

   // Step store is written only while idle, so a running list is stable
   always_ff @(posedge clk_i)
   begin
      if (load_we)
      begin
         step_mem[{load_list_i, load_index_i}] <= load_step_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         for (int i = 0; i < SCS_BUF_BYTES; i++)
            buf_mem[i] <= SCS_BUF_RESET;
      end
      else if (buf_we)
         buf_mem[buf_addr] <= buf_wd;
   end

   scs_spi_shift #(
      .HALF(SCK_HALF)
   ) u_shift (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .start_i(spi_start),
      .tx_i(tx_byte),
      .miso_i(spi_miso_i),
      .sck_o(spi_out.sck),
      .mosi_o(spi_out.mosi),
      .busy_o(),
      .done_o(spi_done),
      .rx_o(spi_rx)
   );

   // Read bytes also stream to the host; a full FIFO stalls the step
   scs_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(rx_push),
      .in_ready_o(fifo_in_ready),
      .in_data_i(spi_rx),
      .out_valid_o(rd_valid_o),
      .out_ready_i(rd_ready_i),
      .out_data_o(rd_data_o)
   );
endmodule : scs_sequencer
`default_nettype wire

// ---- scs_pkg.sv ----
package scs_pkg;

   // Clock and time base
   localparam int unsigned SCS_CLK_PERIOD_NS = 20;
   localparam int unsigned SCS_MS_NS = 1000000;
   localparam int unsigned SCS_MS_CYCLES = SCS_MS_NS / SCS_CLK_PERIOD_NS;

   // Serial clock: half period in system clocks (4 clocks = 80 ns)
   localparam int unsigned SCS_SCK_HALF_CYCLES = 4;

   // Sizes
   localparam int unsigned SCS_BUF_BYTES = 16;
   localparam int unsigned SCS_STEP_DEPTH = 32;
   localparam int unsigned SCS_FIFO_DEPTH = 16;
   localparam int unsigned SCS_LIST_BYTES = 16;

   // Values after reset and fixed bytes
   localparam logic SCS_CS_N_RESET = 1'b1;
   localparam logic [7:0] SCS_BUF_RESET = 8'h00;
   localparam logic [7:0] SCS_FILL_BYTE = 8'hff;
   localparam logic [4:0] SCS_MAX_COUNT = 5'h10;

   // List selector
   localparam logic SCS_LIST_CONNECT = 1'b0;
   localparam logic SCS_LIST_FINISH = 1'b1;

   typedef enum logic [3:0] {
      SCS_ACT_END = 4'h0,
      SCS_ACT_DELAY = 4'h1,
      SCS_ACT_CS_LOW = 4'h2,
      SCS_ACT_CS_HIGH = 4'h3,
      SCS_ACT_WRITE = 4'h4,
      SCS_ACT_VREAD = 4'h5,
      SCS_ACT_VWRITE = 4'h6,
      SCS_ACT_VAND = 4'h7,
      SCS_ACT_VOR = 4'h8,
      SCS_ACT_VXOR = 4'h9
   } scs_action_type;

   // byte_list[7:0] is the first byte sent
   typedef struct packed {
      scs_action_type action;
      logic [15:0] first_operand;
      logic [7:0] second_operand;
      logic [127:0] byte_list;
   } scs_step_type;

   typedef struct packed {
      logic sck;
      logic mosi;
      logic cs_n;
   } scs_spi_out_type;

endpackage : scs_pkg

// ---- scs_fifo.sv ----
`timescale 1ns/1ns
`default_nettype none
module scs_fifo
#(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] cnt_reg;

   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;
   wire wr_last = wr_reg == AW'(DEPTH - 1);
   wire rd_last = rd_reg == AW'(DEPTH - 1);

   assign in_ready_o = cnt_reg != (AW + 1)'(DEPTH);
   assign out_valid_o = cnt_reg != '0;
   assign out_data_o = mem[rd_reg];

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem[wr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end
      else
      begin
         if (push)
            wr_reg <= wr_last ? '0 : wr_reg + 1'b1;
         if (pop)
            rd_reg <= rd_last ? '0 : rd_reg + 1'b1;
         if (push && !pop)
            cnt_reg <= cnt_reg + 1'b1;
         else if (pop && !push)
            cnt_reg <= cnt_reg - 1'b1;
      end
   end
endmodule : scs_fifo
`default_nettype wire

// ---- scs_spi_shift.sv ----
`timescale 1ns/1ns
`default_nettype none
module scs_spi_shift
#(
   parameter int unsigned HALF = 4
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic [7:0] tx_i,
   input wire logic miso_i,
   output logic sck_o,
   output logic mosi_o,
   output logic busy_o,
   output logic done_o,
   output logic [7:0] rx_o
);
   localparam int unsigned DW = $clog2(HALF) + 1;

   logic miso_meta_reg;
   logic miso_reg;
   logic busy_reg;
   logic sck_reg;
   logic mosi_reg;
   logic done_reg;
   logic [DW-1:0] div_reg;
   logic [2:0] bit_reg;
   logic [7:0] tx_reg;
   logic [7:0] rx_reg;

   wire div_end = div_reg == DW'(HALF - 1);

   assign sck_o = sck_reg;
   assign mosi_o = mosi_reg;
   assign busy_o = busy_reg;
   assign done_o = done_reg;
   assign rx_o = rx_reg;

   always_ff @(posedge clk_i)
   begin
      miso_meta_reg <= miso_i;
      miso_reg <= miso_meta_reg;
   end

   // Mode 0; input sampled late in the high phase to absorb sync delay
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         busy_reg <= 1'b0;
         sck_reg <= 1'b0;
         mosi_reg <= 1'b0;
         done_reg <= 1'b0;
         div_reg <= '0;
         bit_reg <= 3'h0;
         tx_reg <= 8'h00;
         rx_reg <= 8'h00;
      end
      else
      begin
         done_reg <= 1'b0;
         if (!busy_reg)
         begin
            if (start_i)
            begin
               busy_reg <= 1'b1;
               tx_reg <= tx_i;
               mosi_reg <= tx_i[7];
               div_reg <= '0;
               bit_reg <= 3'h0;
            end
         end
         else if (!div_end)
            div_reg <= div_reg + 1'b1;
         else
         begin
            div_reg <= '0;
            sck_reg <= !sck_reg;
            if (sck_reg)
            begin
               rx_reg <= {rx_reg[6:0], miso_reg};
               bit_reg <= bit_reg + 1'b1;
               tx_reg <= {tx_reg[6:0], 1'b0};
               mosi_reg <= tx_reg[6];
               busy_reg <= bit_reg != 3'h7;
               done_reg <= bit_reg == 3'h7;
            end
         end
      end
   end
endmodule : scs_spi_shift
`default_nettype wire

// ---- scs_sequencer_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module scs_sequencer_checker
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic connect_req_i,
   input wire logic program_done_i,
   input wire logic connected_o,
   input wire logic connect_done_o,
   input wire logic finish_done_o,
   input wire logic busy_o,
   input wire logic load_ready_o,
   input wire logic rd_valid_o,
   input wire logic rd_ready_i,
   input wire logic [7:0] rd_data_o,
   input wire logic spi_sck_o,
   input wire logic spi_mosi_o,
   input wire logic spi_cs_n_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence sck_high_s;
      spi_sck_o [*4] ##1 !spi_sck_o;
   endsequence
   sequence idle_s;
      !busy_o && !connect_req_i && !(program_done_i && connected_o);
   endsequence

   sck_period_a: assert property ($rose(spi_sck_o) |-> sck_high_s)
      else $error("serial clock high phase has wrong length");
   sck_busy_a: assert property (spi_sck_o |-> busy_o)
      else $error("serial clock runs while idle");
   mosi_hold_a: assert property (spi_sck_o |-> $stable(spi_mosi_o))
      else $error("data out moved while serial clock high");
   cs_idle_a: assert property (!busy_o |=> $stable(spi_cs_n_o))
      else $error("chip select moved outside a step");
   done_pulse_a: assert property (connect_done_o |=>
      !connect_done_o && connected_o)
      else $error("connect done pulse wrong");
   finish_pulse_a: assert property (finish_done_o |=> !finish_done_o)
      else $error("finish done pulse longer than one cycle");
   finish_gate_a: assert property (idle_s |=> !busy_o)
      else $error("list started without a valid request");
   start_run_a: assert property (!busy_o && connect_req_i |=> busy_o)
      else $error("connect request did not start the list");
   ready_idle_a: assert property (load_ready_o != busy_o)
      else $error("step store open while running");
   rd_hold_a: assert property (rd_valid_o && !rd_ready_i |=>
      rd_valid_o && $stable(rd_data_o))
      else $error("read data dropped while stalled");
endmodule : scs_sequencer_checker

bind scs_sequencer scs_sequencer_checker scs_sequencer_checker_inst (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .connect_req_i(connect_req_i),
   .program_done_i(program_done_i), .connected_o(connected_o),
   .connect_done_o(connect_done_o), .finish_done_o(finish_done_o),
   .busy_o(busy_o), .load_ready_o(load_ready_o), .rd_valid_o(rd_valid_o),
   .rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o), .spi_sck_o(spi_sck_o),
   .spi_mosi_o(spi_mosi_o), .spi_cs_n_o(spi_cs_n_o));
`default_nettype wire

// ---- scs_flash_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module scs_flash_model
(
   input wire logic spi_sck_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_mosi_i,
   input wire logic [7:0] seed_i,
   output logic spi_miso_o
);
   int idx = 0;
   int fbit = 0;
   int rbit = 0;
   int rises = 0;
   int frames = 0;
   logic [7:0] sh = 8'h00;
   logic [7:0] got[$];
   logic [7:0] rsp;
   assign rsp = seed_i + 8'(idx) * 8'h3b;
   // Deselected line shows the inverse so a stale copy never matches
   assign spi_miso_o = spi_cs_n_i ? ~rsp[7 - fbit] : rsp[7 - fbit];
   always @(negedge spi_cs_n_i)
   begin
      idx = 0;
      fbit = 0;
      rbit = 0;
      frames++;
   end
   always @(posedge spi_sck_i)
   begin
      rises++;
      if (!spi_cs_n_i)
      begin
         sh = {sh[6:0], spi_mosi_i};
         rbit++;
         if (rbit == 8)
         begin
            got.push_back(sh);
            rbit = 0;
         end
      end
   end
   // Next bit appears after each falling edge, as mode 0 expects
   always @(negedge spi_sck_i)
      if (!spi_cs_n_i)
      begin
         fbit++;
         if (fbit == 8)
         begin
            fbit = 0;
            idx++;
         end
      end
endmodule : scs_flash_model
`default_nettype wire

// ---- scs_sequencer_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module scs_sequencer_tb;
   import scs_pkg::*;
   localparam int MS = 10;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic load_valid = 1'b0;
   logic load_list = 1'b0;
   logic [4:0] load_index = 5'h00;
   scs_step_type load_step = '0;
   logic connect_req = 1'b0;
   logic program_done = 1'b0;
   logic rd_ready = 1'b0;
   logic load_ready, connected, connect_done, finish_done, busy, rd_valid;
   logic [7:0] rd_data;
   logic sck, mosi, cs_n, miso;
   logic [7:0] seed = 8'h00;
   logic [7:0] exp_rd[$];
   logic [7:0] exp_tx[$];
   logic [7:0] vbuf[16];
   logic [15:0] w;
   logic [7:0] v0, v1, v2;
   int err_count = 0;
   int check_count = 0;
   int rd_mode = 0;
   int n1, n2;

   scs_sequencer #(.MS_CYCLES(MS)) scs_sequencer_inst (.clk_i(clk),
      .rst_n_i(rst_n), .load_valid_i(load_valid), .load_ready_o(load_ready),
      .load_list_i(load_list), .load_index_i(load_index),
      .load_step_i(load_step), .connect_req_i(connect_req),
      .program_done_i(program_done), .connected_o(connected),
      .connect_done_o(connect_done), .finish_done_o(finish_done),
      .busy_o(busy), .rd_valid_o(rd_valid), .rd_ready_i(rd_ready),
      .rd_data_o(rd_data), .spi_sck_o(sck), .spi_mosi_o(mosi),
      .spi_cs_n_o(cs_n), .spi_miso_i(miso));
   scs_flash_model flash_inst (.spi_sck_i(sck), .spi_cs_n_i(cs_n),
      .spi_mosi_i(mosi), .seed_i(seed), .spi_miso_o(miso));

   initial forever #10 clk = ~clk;

   function automatic logic [7:0] rsp(int j);
      return seed + 8'(j) * 8'h3b;
   endfunction : rsp

   task automatic chk8(string what, logic [7:0] e, logic [7:0] g);
      check_count++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask : chk8

   task automatic chk32(string what, int e, int g);
      check_count++;
      if (g != e)
      begin
         err_count++;
         $display("[FAIL] %s expected %0d seen %0d", what, e, g);
      end
   endtask : chk32

   task automatic ld(logic l, logic [4:0] i, scs_action_type a,
      logic [15:0] f = 16'h0, logic [7:0] s = 8'h0, logic [127:0] b = 128'h0);
      @(posedge clk);
      load_valid <= 1'b1;
      load_list <= l;
      load_index <= i;
      load_step <= '{a, f, s, b};
      do @(posedge clk); while (load_ready !== 1'b1);
      load_valid <= 1'b0;
   endtask : ld

   task automatic run(logic fin, output int n);
      @(posedge clk);
      if (fin)
         program_done <= 1'b1;
      else
         connect_req <= 1'b1;
      @(posedge clk);
      program_done <= 1'b0;
      connect_req <= 1'b0;
      n = 0;
      while ((fin ? finish_done : connect_done) !== 1'b1 && n < 20000)
      begin
         @(posedge clk);
         n++;
      end
      chk8(fin ? "finish done" : "connect done", 8'h01,
         {7'h0, fin ? finish_done : connect_done});
   endtask : run

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out

   // Far side stalls at random once the buffer refusal was seen
   always @(posedge clk)
      rd_ready <= (rd_mode == 0) ? 1'b0 : (rd_mode == 1) ? 1'($urandom) : 1'b1;
   always @(posedge clk)
      if (rd_valid === 1'b1 && rd_ready === 1'b1)
         chk8("read byte", exp_rd.pop_front(), rd_data);
   always @(posedge clk)
      while (flash_inst.got.size() > 0)
         chk8("sent byte", exp_tx.pop_front(), flash_inst.got.pop_front());

   initial
   begin
      repeat (40000) @(posedge clk);
      err_count++;
      $display("watchdog expired");
      close_out();
   end

   initial
   begin
      void'($urandom(32'hedfa927f));
      seed = 8'($urandom);
      w = 16'($urandom);
      v0 = 8'($urandom);
      v1 = 8'($urandom);
      v2 = 8'($urandom);
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      program_done <= 1'b1;
      @(posedge clk);
      program_done <= 1'b0;
      repeat (5) @(posedge clk);
      chk8("busy", 8'h00, {7'h0, busy});
      $display("end of refused finish");
      ld(1'b0, 5'h00, SCS_ACT_CS_LOW);
      ld(1'b0, 5'h01, SCS_ACT_WRITE, 16'h2, 8'h0, {112'h0, w});
      ld(1'b0, 5'h02, SCS_ACT_VREAD, 16'h0, 8'h10);
      ld(1'b0, 5'h03, SCS_ACT_VREAD, 16'h3, 8'h01);
      ld(1'b0, 5'h04, SCS_ACT_CS_HIGH);
      ld(1'b0, 5'h05, SCS_ACT_VAND, 16'h0, v0);
      ld(1'b0, 5'h06, SCS_ACT_VOR, 16'hf, v1);
      ld(1'b0, 5'h07, SCS_ACT_VXOR, 16'h3, v2);
      ld(1'b0, 5'h08, SCS_ACT_CS_LOW);
      ld(1'b0, 5'h09, SCS_ACT_VWRITE, 16'h0, 8'h10);
      ld(1'b0, 5'h0a, SCS_ACT_VWRITE, 16'he, 8'h04);
      ld(1'b0, 5'h0b, SCS_ACT_CS_HIGH);
      ld(1'b0, 5'h0c, SCS_ACT_END);
      exp_tx.push_back(w[7:0]);
      exp_tx.push_back(w[15:8]);
      for (int i = 0; i < 17; i++)
         exp_tx.push_back(SCS_FILL_BYTE);
      for (int i = 0; i < 16; i++)
         vbuf[i] = rsp(2 + i);
      for (int i = 0; i < 17; i++)
         exp_rd.push_back(rsp(2 + i));
      vbuf[3] = rsp(18);
      vbuf[0] = vbuf[0] & v0;
      vbuf[15] = vbuf[15] | v1;
      vbuf[3] = vbuf[3] ^ v2;
      for (int i = 0; i < 16; i++)
         exp_tx.push_back(vbuf[i]);
      for (int i = 14; i < 18; i++)
         exp_tx.push_back(vbuf[i % 16]);
      fork
         run(1'b0, n1);
         begin
            wait (flash_inst.idx == 18);
            repeat (200) @(posedge clk);
            chk32("bytes before room", 18, flash_inst.idx);
            chk8("read valid", 8'h01, {7'h0, rd_valid});
            chk8("load ready", 8'h00, {7'h0, load_ready});
            rd_mode = 1;
         end
      join
      rd_mode = 2;
      for (int k = 0; k < 500 && exp_rd.size() > 0; k++)
         @(posedge clk);
      chk32("reads left", 0, exp_rd.size());
      chk32("sends left", 0, exp_tx.size());
      chk32("serial clocks", 8 * 39, flash_inst.rises);
      chk32("frames", 2, flash_inst.frames);
      chk8("select idle", 8'h01, {7'h0, cs_n});
      chk8("connected", 8'h01, {7'h0, connected});
      chk8("load ready", 8'h01, {7'h0, load_ready});
      $display("end of connect list");
      ld(1'b1, 5'h00, SCS_ACT_DELAY, 16'h1);
      ld(1'b1, 5'h01, SCS_ACT_END);
      run(1'b1, n1);
      ld(1'b1, 5'h00, SCS_ACT_DELAY, 16'h3);
      run(1'b1, n2);
      chk32("delay span", 2 * MS, n2 - n1);
      $display("end of finish list");
      // Oversized count is capped at 16, a zero count sends nothing
      ld(1'b1, 5'h00, SCS_ACT_CS_LOW);
      ld(1'b1, 5'h01, SCS_ACT_VWRITE, 16'h0, 8'h20);
      ld(1'b1, 5'h02, SCS_ACT_WRITE, 16'h0);
      ld(1'b1, 5'h03, SCS_ACT_CS_HIGH);
      ld(1'b1, 5'h04, SCS_ACT_END);
      for (int i = 0; i < 16; i++)
         exp_tx.push_back(vbuf[i]);
      run(1'b1, n1);
      chk32("capped sends left", 0, exp_tx.size());
      chk32("serial clocks", 8 * 55, flash_inst.rises);
      chk32("frames", 3, flash_inst.frames);
      chk8("select idle", 8'h01, {7'h0, cs_n});
      $display("end of capped write");
      close_out();
   end
endmodule : scs_sequencer_tb
`default_nettype wire
